//--- sbc_pkg.sv
// What this block does
// RQ1: inputs sampled only on rising clock edge
// RQ2: four banks, 8192 rows, 1024 columns
// RQ3: activate opens addressed row in selected bank
// RQ4: read/write start column from low address
// RQ5: command decoded from four strobe pins
// RQ6: deselect ignores commands, work in flight continues
// RQ7: no-operation registers nothing new
// RQ8: autoclose bit applies to one access only
// RQ9: autoclose closes row after burst ends
// RQ10: precharge closes one bank or all banks
// RQ11: refresh is auto or self by clock enable
// RQ12: refresh row comes from internal counter
// RQ13: clock enable high for all other commands
// RQ14: mode load stores address and bank select
// RQ15: mode load only when idle, then wait
// RQ16: row stays open until its bank precharges
// RQ17: read mask floats data two clocks later
// RQ18: write mask blocks store in same cycle
// RQ19: precharged bank idle after precharge time
// RQ20: burst terminate cuts most recent burst
// RQ21: burst follows programmed length and sequence
// RQ22: banks precharged before auto refresh
// RQ23: each bank tracks its own state
`default_nettype none

package sbc_pkg;
   // array geometry, byte-wide variant
   localparam int NBANK       = 4;
   localparam int BA_W        = 2;
   localparam int ROW_W       = 13;
   localparam int COL_W       = 10;
   localparam int DQ_W        = 8;
   localparam int AP_BIT      = 10;
   localparam logic [NBANK-1:0] BANK_ONE = 4'h1;
   localparam logic [NBANK-1:0] BANK_ALL = 4'hF;
   // command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR  = 4'h4;
   localparam logic [3:0] CMD_RD  = 4'h5;
   localparam logic [3:0] CMD_BST = 4'h6;
   localparam logic [3:0] CMD_NOP = 4'h7;
   // mode register layout
   localparam int MODE_ADDR_W = 12;
   localparam int MODE_W      = 14;
   localparam int BL_LSB      = 0;
   localparam int BL_W        = 3;
   localparam int SEQ_BIT     = 3;
   localparam logic [MODE_W-1:0] MODE_RST = 14'h0000;
   localparam logic [BL_W-1:0] BL_1    = 3'h0;
   localparam logic [BL_W-1:0] BL_2    = 3'h1;
   localparam logic [BL_W-1:0] BL_4    = 3'h2;
   localparam logic [BL_W-1:0] BL_8    = 3'h3;
   localparam logic [BL_W-1:0] BL_PAGE = 3'h7;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int PRE_TIME_NS   = 20;
   localparam int PRE_RAW = (PRE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRE_CYC = (PRE_RAW < 1) ? 1 : PRE_RAW;
   localparam int PRE_CNT_W     = 4;
   localparam logic [PRE_CNT_W-1:0] PRE_LOAD = PRE_CNT_W'(PRE_CYC - 1);
   localparam int REF_INT_NS    = 7813;
   localparam int REF_CYC       = REF_INT_NS / CLK_PERIOD_NS;
   localparam int REF_CNT_W     = 7;
   localparam logic [REF_CNT_W-1:0] REF_LOAD = REF_CNT_W'(REF_CYC - 1);
   // state types
   typedef enum logic [1:0] {BK_IDLE, BK_ACTIVE, BK_PRECH} sbc_bank_t;
   typedef enum logic [1:0] {BU_IDLE, BU_READ, BU_WRITE} sbc_burst_t;
endpackage

`default_nettype wire

//--- sbc_col_seq.sv
`timescale 1ns/1ps
`default_nettype none

module sbc_col_seq
   import sbc_pkg::*;
(
   // burst position
   input  wire logic [COL_W-1:0] i_start,
   input  wire logic [COL_W-1:0] i_idx,
   input  wire logic [COL_W-1:0] i_mask,
   input  wire logic             i_inter,
   // column of this beat
   output logic      [COL_W-1:0] o_col
);
   logic [COL_W-1:0] step;

   // wrap inside the burst block, high bits held
   always_comb begin
      step = i_inter ? (i_start ^ i_idx) : (i_start + i_idx);  // RQ21
      o_col = (i_start & ~i_mask) | (step & i_mask);
   end
endmodule

`default_nettype wire

//--- sbc_bank_track.sv
`timescale 1ns/1ps
`default_nettype none

module sbc_bank_track
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_srst,
   // per-bank requests
   input  wire logic [NBANK-1:0]       i_act,
   input  wire logic [NBANK-1:0]       i_pre,
   input  wire logic [ROW_W-1:0]       i_row,
   // bank status
   output logic      [NBANK-1:0]       o_open,
   output logic      [NBANK-1:0]       o_idle,
   output logic      [NBANK*ROW_W-1:0] o_rows
);
   genvar b;
   generate
      for (b = 0; b < NBANK; b++) begin : g_bank  // RQ2
         sbc_bank_t            state, next_state;
         logic [ROW_W-1:0]     row, next_row;
         logic [PRE_CNT_W-1:0] cnt, next_cnt;
         logic                 open, idle;

         // one bank: idle, row open, precharging
         always_comb begin
            next_state = state;
            next_row   = row;
            next_cnt   = cnt;
            unique case (state)
               BK_IDLE: if (i_act[b]) begin
                  next_state = BK_ACTIVE;  // RQ23
                  next_row   = i_row;  // RQ3
               end
               BK_ACTIVE: if (i_pre[b]) begin
                  next_state = BK_PRECH;  // RQ16
                  next_cnt   = PRE_LOAD;
               end
               BK_PRECH: if (cnt == '0) begin
                  next_state = BK_IDLE;  // RQ19
               end else begin
                  next_cnt = cnt - 1'b1;
               end
               default: next_state = BK_IDLE;
            endcase
         end

         always_ff @(posedge i_core_clk) begin
            if (i_srst) begin
               state <= BK_IDLE;
               row   <= '0;
               cnt   <= '0;
               open  <= 1'b0;
               idle  <= 1'b1;
            end else begin
               state <= next_state;
               row   <= next_row;
               cnt   <= next_cnt;
               open  <= (next_state == BK_ACTIVE);
               idle  <= (next_state == BK_IDLE);
            end
         end

         assign o_open[b] = open;
         assign o_idle[b] = idle;
         assign o_rows[b*ROW_W +: ROW_W] = row;
      end
   endgenerate
endmodule

`default_nettype wire

//--- sbc_sdram_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module sbc_sdram_ctrl
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic              i_core_clk,
   input  wire logic              i_srst,
   // command pins
   input  wire logic              i_cke,
   input  wire logic              i_cs_n,
   input  wire logic              i_ras_n,
   input  wire logic              i_cas_n,
   input  wire logic              i_we_n,
   input  wire logic              i_bank_select_lo,
   input  wire logic              i_bank_select_hi,
   input  wire logic [ROW_W-1:0]  i_addr,
   // data pins
   input  wire logic              i_dqm,
   input  wire logic [DQ_W-1:0]   i_dq,
   output logic      [DQ_W-1:0]   o_dq,
   output logic                   o_dq_oe,
   // storage array port
   output logic                   o_arr_rd_en,
   output logic                   o_arr_wr_en,
   output logic                   o_arr_ref_en,
   output logic      [BA_W-1:0]   o_arr_bank,
   output logic      [ROW_W-1:0]  o_arr_row,
   output logic      [COL_W-1:0]  o_arr_col,
   output logic      [DQ_W-1:0]   o_arr_wdata,
   input  wire logic [DQ_W-1:0]   i_arr_rdata,
   // status
   output logic      [NBANK-1:0]  o_bank_open,
   output logic                   o_self_refresh,
   output logic      [MODE_W-1:0] o_mode_reg
);
   // command decode
   logic [3:0]             cmd;
   logic [BA_W-1:0]        bank_sel;
   logic                   sel;
   logic                   live;
   logic                   c_act;
   logic                   c_rd;
   logic                   c_wr;
   logic                   c_bst;
   logic                   c_pre;
   logic                   c_mrs;
   logic                   c_ref;
   logic                   all_idle;
   // bank tracking
   logic [NBANK-1:0]       bank_idle;
   logic [NBANK*ROW_W-1:0] bank_rows;
   logic [NBANK-1:0]       act_req;
   logic [NBANK-1:0]       pre_req;
   logic [NBANK-1:0]       close_req;
   // burst engine
   sbc_burst_t             bstate, next_bstate;
   logic [BA_W-1:0]        bbank, next_bbank;
   logic [COL_W-1:0]       bstart, next_bstart;
   logic [COL_W-1:0]       bidx, next_bidx;
   logic                   bap, next_bap;
   logic                   start;
   logic                   beat_go;
   logic                   beat_rd;
   logic                   beat_wr;
   logic                   last;
   logic                   full_page;
   logic [BA_W-1:0]        beat_bank;
   logic [COL_W-1:0]       beat_start;
   logic [COL_W-1:0]       beat_idx;
   logic [COL_W-1:0]       beat_col;
   logic [COL_W-1:0]       len_m1;
   logic [COL_W-1:0]       col_mask;
   // mode and refresh
   logic [MODE_W-1:0]      next_mode;
   logic [ROW_W-1:0]       ref_row, next_ref_row;
   logic [REF_CNT_W-1:0]   sr_cnt, next_sr_cnt;
   logic                   next_sr;
   logic                   ref_go;
   // array and data path
   logic                   next_rd, next_wr, next_ref;
   logic [BA_W-1:0]        next_bank;
   logic [ROW_W-1:0]       next_row;
   logic [COL_W-1:0]       next_col;
   logic [DQ_W-1:0]        next_wdata;
   logic [DQ_W-1:0]        next_dq;
   logic                   next_oe;
   logic                   dqm_d1;

   // pin code, bank number
   assign cmd      = {i_cs_n, i_ras_n, i_cas_n, i_we_n};  // RQ5
   assign bank_sel = {i_bank_select_hi, i_bank_select_lo};

   // deselect and self refresh drop new commands
   assign sel  = !i_cs_n && !o_self_refresh;  // RQ6
   assign live = sel && i_cke;  // RQ13

   // no-operation matches none of these and falls through
   assign c_act    = live && (cmd == CMD_ACT) && bank_idle[bank_sel];  // RQ7
   assign c_rd     = live && (cmd == CMD_RD) && o_bank_open[bank_sel];  // RQ19
   assign c_wr     = live && (cmd == CMD_WR) && o_bank_open[bank_sel];
   assign c_bst    = live && (cmd == CMD_BST);
   assign c_pre    = live && (cmd == CMD_PRE);
   assign c_mrs    = live && (cmd == CMD_MRS) && all_idle;
   assign c_ref    = sel && (cmd == CMD_REF) && all_idle;  // RQ11
   assign all_idle = &bank_idle;

   // burst length from the mode register
   always_comb begin
      full_page = (o_mode_reg[BL_LSB +: BL_W] == BL_PAGE);
      case (o_mode_reg[BL_LSB +: BL_W])
         BL_2:    len_m1 = 10'h001;
         BL_4:    len_m1 = 10'h003;
         BL_8:    len_m1 = 10'h007;
         BL_PAGE: len_m1 = 10'h3FF;
         default: len_m1 = 10'h000;
      endcase
      col_mask = len_m1;  // RQ21
   end

   // beat source: fresh command or burst in flight
   assign start      = c_rd || c_wr;
   assign beat_start = start ? i_addr[COL_W-1:0] : bstart;  // RQ4
   assign beat_idx   = start ? '0 : bidx;
   assign beat_bank  = start ? bank_sel : bbank;
   assign last       = !full_page && (beat_idx == len_m1);
   assign beat_rd    = beat_go && (start ? c_rd : (bstate == BU_READ));
   assign beat_wr    = beat_go && !beat_rd;

   // column walk, sequential or interleaved
   sbc_col_seq u_col (
      .i_start (beat_start),
      .i_idx   (beat_idx),
      .i_mask  (col_mask),
      .i_inter (o_mode_reg[SEQ_BIT]),
      .o_col   (beat_col)
   );

   // burst engine next state
   always_comb begin
      next_bstate = bstate;
      next_bbank  = bbank;
      next_bstart = bstart;
      next_bidx   = bidx;
      next_bap    = bap;
      close_req   = '0;
      beat_go     = 1'b0;
      unique case (bstate)
         BU_IDLE, BU_READ, BU_WRITE: begin
            if (start) begin
               // newest access replaces any burst in flight
               beat_go     = 1'b1;
               next_bbank  = bank_sel;
               next_bstart = i_addr[COL_W-1:0];
               next_bap    = i_addr[AP_BIT];  // RQ8
               next_bidx   = 10'h001;
               next_bstate = c_rd ? BU_READ : BU_WRITE;
               if (last) begin
                  next_bstate = BU_IDLE;
                  if (i_addr[AP_BIT]) begin
                     close_req = BANK_ONE << bank_sel;  // RQ9
                  end
               end
            end else if (bstate != BU_IDLE) begin
               if (c_bst || (c_pre && (i_addr[AP_BIT] || bank_sel == bbank))) begin
                  next_bstate = BU_IDLE;  // RQ20
                  if (bap) begin
                     close_req = BANK_ONE << bbank;
                  end
               end else begin
                  beat_go   = 1'b1;
                  next_bidx = bidx + 10'h001;
                  if (last) begin
                     next_bstate = BU_IDLE;
                     if (bap) begin
                        close_req = BANK_ONE << bbank;  // RQ9
                     end
                  end
               end
            end
         end
         default: next_bstate = BU_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         bstate <= BU_IDLE;
         bbank  <= '0;
         bstart <= '0;
         bidx   <= '0;
         bap    <= 1'b0;
      end else begin
         bstate <= next_bstate;
         bbank  <= next_bbank;
         bstart <= next_bstart;
         bidx   <= next_bidx;
         bap    <= next_bap;
      end
   end

   // bank open and close requests
   assign act_req = c_act ? (BANK_ONE << bank_sel) : '0;  // RQ3
   assign pre_req = close_req
                  | (!c_pre ? '0 : i_addr[AP_BIT] ? BANK_ALL : (BANK_ONE << bank_sel));  // RQ10

   sbc_bank_track u_banks (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .i_act      (act_req),
      .i_pre      (pre_req),
      .i_row      (i_addr),
      .o_open     (o_bank_open),
      .o_idle     (bank_idle),
      .o_rows     (bank_rows)
   );

   // mode load, refresh counter, self refresh timer
   always_comb begin
      next_mode    = o_mode_reg;
      next_ref_row = ref_row;
      next_sr_cnt  = sr_cnt;
      next_sr      = o_self_refresh;
      ref_go       = 1'b0;
      if (c_mrs) begin
         next_mode = {bank_sel, i_addr[MODE_ADDR_W-1:0]};  // RQ14
      end
      if (o_self_refresh) begin
         if (i_cke) begin
            next_sr = 1'b0;
         end else if (sr_cnt == '0) begin
            ref_go      = 1'b1;
            next_sr_cnt = REF_LOAD;
         end else begin
            next_sr_cnt = sr_cnt - 1'b1;
         end
      end else if (c_ref) begin
         ref_go      = 1'b1;
         next_sr     = !i_cke;  // RQ11
         next_sr_cnt = REF_LOAD;
      end
      if (ref_go) begin
         next_ref_row = ref_row + 13'h0001;  // RQ12
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_mode_reg     <= MODE_RST;
         ref_row        <= '0;
         sr_cnt         <= '0;
         o_self_refresh <= 1'b0;
      end else begin
         o_mode_reg     <= next_mode;
         ref_row        <= next_ref_row;
         sr_cnt         <= next_sr_cnt;
         o_self_refresh <= next_sr;
      end
   end

   // array strobes and data pins
   always_comb begin
      next_rd    = beat_rd;
      next_wr    = beat_wr && !i_dqm;  // RQ18
      next_ref   = ref_go;
      next_bank  = beat_bank;
      next_row   = ref_go ? ref_row : bank_rows[beat_bank*ROW_W +: ROW_W];
      next_col   = beat_col;
      next_wdata = i_dq;
      next_dq    = o_arr_rd_en ? i_arr_rdata : o_dq;
      next_oe    = o_arr_rd_en && !dqm_d1;  // RQ17
   end

   // every pin sampled on the rising edge only
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_arr_rd_en  <= 1'b0;
         o_arr_wr_en  <= 1'b0;
         o_arr_ref_en <= 1'b0;
         o_arr_bank   <= '0;
         o_arr_row    <= '0;
         o_arr_col    <= '0;
         o_arr_wdata  <= '0;
         o_dq         <= '0;
         o_dq_oe      <= 1'b0;
         dqm_d1       <= 1'b0;
      end else begin
         o_arr_rd_en  <= next_rd;  // RQ1
         o_arr_wr_en  <= next_wr;
         o_arr_ref_en <= next_ref;
         o_arr_bank   <= next_bank;
         o_arr_row    <= next_row;
         o_arr_col    <= next_col;
         o_arr_wdata  <= next_wdata;
         o_dq         <= next_dq;
         o_dq_oe      <= next_oe;
         dqm_d1       <= i_dqm;
      end
   end

   // checks on the command and data behaviour
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   inhibit_hold_a:  // RQ6
      assert property ((i_cs_n && bstate == BU_IDLE) |=> bstate == BU_IDLE)
      else $error("burst started while deselected");

   nop_quiet_a:  // RQ7
      assert property ((!i_cs_n && cmd == CMD_NOP && bstate == BU_IDLE)
                       |=> $stable(o_bank_open))
      else $error("no-operation changed bank state");

   act_row_a:  // RQ3
      assert property (c_act |=> (o_bank_open[$past(bank_sel)]
                       && bank_rows[$past(bank_sel)*ROW_W +: ROW_W] == $past(i_addr)))
      else $error("activate did not open the addressed row");

   ap_latch_a:  // RQ8
      assert property (start |=> bap == $past(i_addr[AP_BIT]))
      else $error("autoclose flag not taken from this access");

   ap_close_a:  // RQ9
      assert property ((beat_go && last && !start && !c_pre)
                       |=> o_bank_open[$past(bbank)] == !$past(bap))
      else $error("row state wrong at burst end");

   pre_all_a:  // RQ10
      assert property ((c_pre && i_addr[AP_BIT]) |=> o_bank_open == '0)
      else $error("precharge all left a bank open");

   ref_mode_a:  // RQ11
      assert property (c_ref |=> (o_arr_ref_en && o_self_refresh == !$past(i_cke)))
      else $error("refresh kind does not follow clock enable");

   ref_row_a:  // RQ12
      assert property (ref_go |=> (o_arr_row == $past(ref_row)
                       && ref_row == $past(ref_row) + 13'h0001))
      else $error("refresh row not from internal counter");

   mode_load_a:  // RQ14
      assert property (c_mrs |=> o_mode_reg == $past({bank_sel, i_addr[MODE_ADDR_W-1:0]}))
      else $error("mode register not loaded");

   dq_mask_a:  // RQ17
      assert property (beat_rd |-> ##2 (o_dq_oe == !$past(i_dqm, 2)))
      else $error("read mask not honoured two clocks later");

   wr_mask_a:  // RQ18
      assert property (beat_wr |=> o_arr_wr_en == !$past(i_dqm))
      else $error("masked write reached the array");

   bst_cut_a:  // RQ20
      assert property ((c_bst && !start) |=> bstate == BU_IDLE)
      else $error("burst terminate did not stop the burst");

   burst_len_a:  // RQ21
      assert property ((start && !full_page && len_m1 == 10'h003 && o_mode_reg[SEQ_BIT] == 1'b0
                        && !i_addr[AP_BIT])
                       ##1 (beat_go && !start) [*3] |=> bstate == BU_IDLE)
      else $error("four-beat burst did not end on time");
endmodule

`default_nettype wire

//--- sbc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

module sbc_ctl_model
   import sbc_pkg::*;
(
   // clock
   input  wire logic             i_core_clk,
   // command pins
   output logic                  o_cke,
   output logic      [3:0]       o_cmd,
   output logic      [BA_W-1:0]  o_bank,
   output logic      [ROW_W-1:0] o_addr,
   // data pins
   output logic                  o_dqm,
   output logic      [DQ_W-1:0]  o_dq
);
   // pins rest on a nop with clock enable high
   initial begin
      o_cke  = 1'b1;
      o_cmd  = CMD_NOP;
      o_bank = 2'h0;
      o_addr = 13'h0000;
      o_dqm  = 1'b0;
      o_dq   = 8'h00;
   end

   // one command cycle, launched just after the sampling edge
   task automatic issue(input logic [3:0] c, input logic [BA_W-1:0] b,
                        input logic [ROW_W-1:0] a, input logic m,
                        input logic [DQ_W-1:0] d, input logic e);
      @(posedge i_core_clk);
      #1;
      o_cmd  = c;
      o_bank = b;
      o_addr = a;
      o_dqm  = m;
      o_dq   = d;
      o_cke  = e;
   endtask

   // nop cycle; unused lines flip so stale values never look valid
   task automatic idle(input logic m, input logic [DQ_W-1:0] d, input logic e);
      issue(CMD_NOP, ~o_bank, ~o_addr, m, d, e);
   endtask

   // gaps after mode load and precharge
   task automatic settle(input int n);
      repeat (n) idle(1'b0, ~o_dq, 1'b1);
   endtask
endmodule

`default_nettype wire

//--- sdram_command_bank_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_command_bank_control_bench;
   import sbc_pkg::*;
   logic              clk, srst, cke, dqm, dq_oe, rd_en, wr_en, ref_en, self_ref;
   logic [3:0]        cmd, bank_open;
   logic [BA_W-1:0]   bank, a_bank, b, b2;
   logic [ROW_W-1:0]  addr, a_row, r0;
   logic [COL_W-1:0]  a_col, c;
   logic [DQ_W-1:0]   wdq, rdq, a_wdata, a_rdata, d0;
   logic [MODE_W-1:0] mode_reg;
   logic [15:0]       lf = 16'hDC5E;
   logic [ROW_W-1:0]  rows [4];
   logic [DQ_W-1:0]   mem [logic [24:0]];
   logic [2:0]        cds [5] = '{BL_1, BL_2, BL_4, BL_8, BL_PAGE};
   int                n_errors, n_compared, wr_cnt, rd_cnt, ref_cnt, pre, i, k, bl;

   sbc_ctl_model i_sbc_ctl_model (.i_core_clk(clk), .o_cke(cke), .o_cmd(cmd),
      .o_bank(bank), .o_addr(addr), .o_dqm(dqm), .o_dq(wdq));
   sbc_sdram_ctrl i_sbc_sdram_ctrl (.i_core_clk(clk), .i_srst(srst), .i_cke(cke),
      .i_cs_n(cmd[3]), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
      .i_bank_select_lo(bank[0]), .i_bank_select_hi(bank[1]), .i_addr(addr),
      .i_dqm(dqm), .i_dq(wdq), .o_dq(rdq), .o_dq_oe(dq_oe), .o_arr_rd_en(rd_en),
      .o_arr_wr_en(wr_en), .o_arr_ref_en(ref_en), .o_arr_bank(a_bank),
      .o_arr_row(a_row), .o_arr_col(a_col), .o_arr_wdata(a_wdata),
      .i_arr_rdata(a_rdata), .o_bank_open(bank_open), .o_self_refresh(self_ref),
      .o_mode_reg(mode_reg));

   // clock generation
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // untouched array cells hold a pattern of their address
   function automatic logic [7:0] fill(logic [24:0] key);
      return key[7:0] ^ 8'hA5;
   endfunction
   function automatic logic [7:0] rd_val(logic [1:0] bk, logic [12:0] rw, logic [9:0] cl);
      return mem.exists({bk, rw, cl}) ? mem[{bk, rw, cl}] : fill({bk, rw, cl});
   endfunction
   assign a_rdata = rd_val(a_bank, a_row, a_col);

   // storage array and strobe counters
   always @(posedge clk) begin
      if (wr_en) begin
         mem[{a_bank, a_row, a_col}] = a_wdata;
      end
      wr_cnt += int'(wr_en);
      rd_cnt += int'(rd_en);
      ref_cnt += int'(ref_en);
   end

   function automatic logic [15:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf;
   endfunction
   // column of beat i for a burst of length n
   function automatic logic [9:0] exp_col(logic [9:0] s, int i, int n, logic il);
      logic [9:0] m;
      m = 10'(n - 1);
      return il ? (s & ~m) | ((s ^ 10'(i)) & m) : (s & ~m) | ((s + 10'(i)) & m);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmd_go(input logic [3:0] op, input logic [1:0] bk, input logic [12:0] ad);
      i_sbc_ctl_model.issue(op, bk, ad, 1'b0, 8'(rnd()), 1'b1);
   endtask
   task automatic nops(input int n);
      i_sbc_ctl_model.settle(n);
   endtask

   // main sequence
   initial begin
      srst = 1'b1;
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      check(bank_open, 0);
      check(mode_reg, MODE_RST);
      check({self_ref, dq_oe, rd_en, wr_en, ref_en}, 0);
      // mode load, burst of two, sequential
      r0 = {1'b0, 8'(rnd()), 4'h1};
      cmd_go(CMD_MRS, 2'h2, r0);
      nops(2);
      check(mode_reg, {2'h2, r0[11:0]});
      // activate with clock enable low, then deselected
      i_sbc_ctl_model.issue(CMD_ACT, 2'h1, 13'h0010, 1'b0, 8'h00, 1'b0);
      cmd_go(4'hB, 2'h1, 13'h0010);
      nops(1);
      check(bank_open, 0);
      for (k = 0; k < 4; k++) begin
         rows[k] = 13'(rnd());
         cmd_go(CMD_ACT, 2'(k), rows[k]);
      end
      nops(1);
      check(bank_open, BANK_ALL);
      // write of two beats, second masked
      b = 2'(rnd());
      c = 10'(rnd());
      d0 = 8'(rnd());
      pre = wr_cnt;
      i_sbc_ctl_model.issue(CMD_WR, b, {3'h0, c}, 1'b0, d0, 1'b1);
      i_sbc_ctl_model.idle(1'b1, ~d0, 1'b1);
      nops(2);
      check(wr_cnt - pre, 1);
      check(bank_open, BANK_ALL);
      // read back with autoclose
      cmd_go(CMD_RD, b, {3'h1, c});
      nops(1);
      check({rd_en, a_row, a_col}, {1'b1, rows[b], exp_col(c, 0, 2, 1'b0)});
      check(a_bank, b);
      nops(1);
      check({dq_oe, rdq}, {1'b1, d0});
      check(bank_open, BANK_ALL & ~(BANK_ONE << b));
      nops(1);
      check(rdq, fill({b, rows[b], exp_col(c, 1, 2, 1'b0)}));
      nops(1);
      check(dq_oe, 0);
      // plain read with first beat masked keeps row open
      b2 = b + 2'h1;
      i_sbc_ctl_model.issue(CMD_RD, b2, {3'h0, c}, 1'b1, 8'h00, 1'b1);
      nops(2);
      check(dq_oe, 0);
      nops(1);
      check(dq_oe, 1);
      check(bank_open, BANK_ALL & ~(BANK_ONE << b));
      cmd_go(CMD_PRE, b2, 13'h0000);
      nops(2);
      check(bank_open, BANK_ALL & ~(BANK_ONE << b) & ~(BANK_ONE << b2));
      pre = rd_cnt;
      cmd_go(CMD_RD, b2, {3'h0, c});
      nops(2);
      check(rd_cnt - pre, 0);
      cmd_go(CMD_PRE, 2'(rnd()), 13'h0400);
      nops(2);
      check(bank_open, 0);
      // two auto refreshes, then self refresh
      cmd_go(CMD_REF, 2'(rnd()), 13'(rnd()));
      nops(1);
      check(ref_en, 1);
      r0 = a_row;
      cmd_go(CMD_REF, 2'(rnd()), 13'(rnd()));
      nops(1);
      check({ref_en, a_row}, {1'b1, r0 + 13'h0001});
      i_sbc_ctl_model.issue(CMD_REF, 2'h0, 13'(rnd()), 1'b0, 8'h00, 1'b0);
      i_sbc_ctl_model.idle(1'b0, 8'h00, 1'b0);
      check(self_ref, 1);
      // let the entry pulse be counted, then time the first internal one
      i_sbc_ctl_model.idle(1'b0, 8'h00, 1'b0);
      pre = ref_cnt;
      for (i = 0; i < 100 && ref_cnt == pre; i++) i_sbc_ctl_model.idle(1'b0, 8'h00, 1'b0);
      check(ref_cnt - pre, 1);
      check(i, REF_CYC);
      nops(2);
      check(self_ref, 0);
      // burst lengths and orders, page burst cut short
      for (k = 0; k < 9; k++) begin
         bl = (cds[k >> 1] == BL_PAGE) ? 3 : (1 << cds[k >> 1]);
         cmd_go(CMD_PRE, 2'h0, 13'h0400);
         nops(2);
         cmd_go(CMD_MRS, 2'h0, {9'h000, k[0], cds[k >> 1]});
         nops(2);
         b = 2'(rnd());
         c = 10'(rnd());
         cmd_go(CMD_ACT, b, 13'(rnd()));
         cmd_go(CMD_RD, b, {3'h0, c});
         for (i = 0; i < bl; i++) begin
            nops(1);
            check({rd_en, a_col}, {1'b1, exp_col(c, i, bl > 3 || k < 8 ? bl : 1024, k[0])});
         end
         if (k == 8) cmd_go(CMD_BST, 2'h0, 13'h0000);
         nops(1);
         check(rd_en, 0);
      end
      stop_test();
   end
endmodule

`default_nettype wire
